// ---- hdl/opc_regs.sv ----
`timescale 1ns/1ns
// How it works
// - overlay address bit 31 reads flip pending
// - bit 27 picks local or host memory
// - overlay start address bits 25:4 stored
// - separate last-byte address with source bit
// - window width 29:20, pitch 13:4
// - top line 26:16, left pixel 10:0
// - bottom line 26:16, right pixel 10:0
// - bits 31/15 choose shrink or expand
// - initial vertical and horizontal scale seeds
// - key compare skips masked bit positions
// - eight palette words, even low odd high
// - cursor shown only while bit 31 set
// - cursor address bits 25:4, low zero
// - cursor Y/X with top/left overhang flags
// - three cursor colours over two words
// - bit 28 picks constant or pixel alpha
// - fifo request at coded empty level
// - bits 7:4 give panning start pixel
// - bit 3 keying on, bit 2 plane on
// - blend plane format decode, 00 reserved
// - fixed low bits always read zero
// - overlay format code decode
module opc_regs
	import opc_pkg::*;
#(
	parameter int FIFO_CNT_W = 4
)(
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [ADDR_W-1:0]     reg_addr,
	input  wire logic [31:0]           reg_wdata,
	output logic      [31:0]           reg_rdata,
	output logic                       reg_rd_valid,
	input  wire logic                  vsync,
	input  wire logic                  ovl_key_enable,
	input  wire logic [15:0]           ovl_pixel,
	input  wire logic [3:0]            ovl_pixel_index,
	input  wire logic [1:0]            ovl_format_code,
	input  wire logic [3:0]            blend_pixel_alpha,
	input  wire logic [FIFO_CNT_W-1:0] blend_fifo_empty,
	output logic      [31:0]           ovl_fb_live,
	output logic                       ovl_flip_pending,
	output logic                       ovl_fb_end_ext,
	output logic      [21:0]           ovl_fb_end,
	output logic      [9:0]            ovl_window_width,
	output logic      [9:0]            line_pitch,
	output logic      [10:0]           ovl_top,
	output logic      [10:0]           ovl_left,
	output logic      [10:0]           ovl_bottom,
	output logic      [10:0]           ovl_right,
	output logic                       vert_shrink_sel,
	output logic                       horiz_shrink_sel,
	output logic      [11:0]           vert_ratio,
	output logic      [11:0]           horiz_ratio,
	output logic      [11:0]           vert_ratio_init,
	output logic      [11:0]           horiz_ratio_init,
	output logic                       ovl_key_transparent,
	output logic      [15:0]           ovl_palette_color,
	output opc_fmt_t                   ovl_format,
	output logic                       pointer_sprite_show,
	output logic                       pointer_sprite_ext,
	output logic      [21:0]           pointer_sprite_addr,
	output logic      [10:0]           pointer_sprite_y,
	output logic      [10:0]           pointer_sprite_x,
	output logic                       pointer_sprite_top_clip,
	output logic                       pointer_sprite_left_clip,
	output logic      [15:0]           cursor_shade_a,
	output logic      [15:0]           cursor_shade_b,
	output logic      [15:0]           cursor_shade_c,
	output logic      [3:0]            blend_alpha,
	output logic                       blend_fifo_req,
	output logic      [3:0]            blend_pan_start,
	output logic                       key_match_on,
	output logic                       blend_plane_on,
	output opc_fmt_t                   blend_format,
	output logic                       blend_format_bad
);

	// refuse a fifo count too narrow to hold the highest request level
	if (FIFO_CNT_W < 4)
	begin : g_width_check
		$error("opc_regs: FIFO_CNT_W must reach a count of 11");
	end

	logic [31:0] regs [REG_COUNT];
	logic        flip_pend;

	// address decode, also used by the read path
	function automatic logic [4:0] opc_decode(input logic [ADDR_W-1:0] a);
		logic [4:0] r;
		r = IDX_NONE;
		if (a[1:0] == 2'h0)
		begin
			unique case (a)
				OFS_OVL_FB_ADDR: r = IDX_OVL_FB_ADDR;
				OFS_OVL_PITCH:   r = IDX_OVL_PITCH;
				OFS_OVL_FB_END:  r = IDX_OVL_FB_END;
				OFS_OVL_TL:      r = IDX_OVL_TL;
				OFS_OVL_BR:      r = IDX_OVL_BR;
				OFS_OVL_SCALE:   r = IDX_OVL_SCALE;
				OFS_OVL_INIT:    r = IDX_OVL_INIT;
				OFS_OVL_KEY:     r = IDX_OVL_KEY;
				OFS_CUR_ADDR:    r = IDX_CUR_ADDR;
				OFS_CUR_POS:     r = IDX_CUR_POS;
				OFS_CUR_COL12:   r = IDX_CUR_COL12;
				OFS_CUR_COL3:    r = IDX_CUR_COL3;
				OFS_BLEND_CTRL:  r = IDX_BLEND_CTRL;
				default:
				begin
					if (a >= OFS_OVL_PAL_LO && a <= OFS_OVL_PAL_HI)
						r = IDX_OVL_PAL + 5'((a - OFS_OVL_PAL_LO) >> 2);
				end
			endcase
		end
		return r;
	endfunction : opc_decode

	// storable bits of each word; everything else reads zero, except overlay address bit 31, which reads flip pending
	function automatic logic [31:0] opc_mask(input logic [4:0] i);
		logic [31:0] m;
		m = MASK_NONE;
		unique case (i)
			IDX_OVL_FB_ADDR: m = MASK_FB_ADDR;
			IDX_OVL_PITCH:   m = MASK_PITCH;
			IDX_OVL_FB_END:  m = MASK_FB_ADDR;
			IDX_OVL_TL:      m = MASK_CORNER;
			IDX_OVL_BR:      m = MASK_CORNER;
			IDX_OVL_SCALE:   m = MASK_SCALE;
			IDX_OVL_INIT:    m = MASK_INIT;
			IDX_OVL_KEY:     m = MASK_FULL;
			IDX_CUR_ADDR:    m = MASK_CUR_ADDR;
			IDX_CUR_POS:     m = MASK_CUR_POS;
			IDX_CUR_COL12:   m = MASK_FULL;
			IDX_CUR_COL3:    m = MASK_LOW_HALF;
			IDX_BLEND_CTRL:  m = MASK_BLEND_CTRL;
			default:
			begin
				if (i >= IDX_OVL_PAL && i < IDX_CUR_ADDR)
					m = MASK_FULL;
			end
		endcase
		return m;
	endfunction : opc_mask

	// fifo request threshold from the two-bit level code
	function automatic logic [3:0] opc_fifo_level(input logic [1:0] c);
		logic [3:0] l;
		l = FIFO_LVL_0;
		unique case (c)
			2'h0: l = FIFO_LVL_0;
			2'h1: l = FIFO_LVL_1;
			2'h2: l = FIFO_LVL_2;
			2'h3: l = FIFO_LVL_3;
		endcase
		return l;
	endfunction : opc_fifo_level

	wire logic [4:0]  wr_idx      = opc_decode(reg_addr);
	wire logic [31:0] wr_mask     = opc_mask(wr_idx);
	wire logic        wr_hit      = reg_wr && (wr_mask != MASK_NONE);
	wire logic        fb_addr_wr  = reg_wr && (wr_idx == IDX_OVL_FB_ADDR);
	wire logic [31:0] rd_word     = (wr_idx == IDX_NONE) ? REG_RESET
	                                : (regs[wr_idx] & wr_mask);
	wire logic [31:0] rd_status   = (wr_idx == IDX_OVL_FB_ADDR)
	                                ? {flip_pend, rd_word[30:0]} : rd_word;

	wire logic [31:0] key_word    = regs[IDX_OVL_KEY];
	wire logic        key_equal   = &((ovl_pixel ~^ key_word[15:0]) | key_word[31:16]);
	wire logic [31:0] pal_word    = regs[IDX_OVL_PAL + {2'h0, ovl_pixel_index[3:1]}];
	wire logic [15:0] pal_color   = ovl_pixel_index[0] ? pal_word[31:16]
	                                : pal_word[15:0];
	wire logic [31:0] bctl        = regs[IDX_BLEND_CTRL];
	wire logic [3:0]  next_alpha  = bctl[BIT_ALPHA_SEL] ? bctl[27:24]
	                                : blend_pixel_alpha;
	wire logic        next_req    = blend_fifo_empty
	                                >= FIFO_CNT_W'(opc_fifo_level(bctl[17:16]));

	// register storage: only the storable bits change
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < REG_COUNT; i++)
				regs[i] <= REG_RESET;
		end
		else if (wr_hit)
		begin
			regs[wr_idx] <= (regs[wr_idx] & ~wr_mask) | (reg_wdata & wr_mask);
		end
	end

	// flip pending: a new address set wins over the vsync take-up
	always_ff @(posedge clk)
	begin
		if (reset)
			flip_pend <= 1'b0;
		else if (fb_addr_wr)
			flip_pend <= 1'b1;
		else if (vsync)
			flip_pend <= 1'b0;
	end

	// live address taken up by the display at vsync
	always_ff @(posedge clk)
	begin
		if (reset)
			ovl_fb_live <= REG_RESET;
		else if (vsync && flip_pend && !fb_addr_wr)
			ovl_fb_live <= regs[IDX_OVL_FB_ADDR] & MASK_FB_ADDR;
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			reg_rdata    <= REG_RESET;
			reg_rd_valid <= 1'b0;
		end
		else
		begin
			reg_rd_valid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rd_status;
		end
	end

	// per-pixel results
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ovl_key_transparent <= 1'b0;
			ovl_palette_color   <= 16'h0000;
			blend_alpha         <= 4'h0;
			blend_fifo_req      <= 1'b0;
		end
		else
		begin
			ovl_key_transparent <= ovl_key_enable && key_equal;
			ovl_palette_color   <= pal_color;
			blend_alpha         <= next_alpha;
			blend_fifo_req      <= next_req;
		end
	end

	// format decodes
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ovl_format       <= FMT_INDEX8;
			blend_format     <= FMT_INDEX8;
			blend_format_bad <= 1'b0;
		end
		else
		begin
			ovl_format       <= opc_fmt_t'(ovl_format_code);
			blend_format     <= opc_fmt_t'(bctl[1:0]);
			blend_format_bad <= (bctl[1:0] == 2'h0);
		end
	end

	assign ovl_flip_pending         = flip_pend;
	assign ovl_fb_end_ext           = regs[IDX_OVL_FB_END][BIT_EXT_SRC];
	assign ovl_fb_end               = regs[IDX_OVL_FB_END][25:4];
	assign ovl_window_width         = regs[IDX_OVL_PITCH][29:20];
	assign line_pitch               = regs[IDX_OVL_PITCH][13:4];
	assign ovl_top                  = regs[IDX_OVL_TL][26:16];
	assign ovl_left                 = regs[IDX_OVL_TL][10:0];
	assign ovl_bottom               = regs[IDX_OVL_BR][26:16];
	assign ovl_right                = regs[IDX_OVL_BR][10:0];
	assign vert_shrink_sel          = regs[IDX_OVL_SCALE][BIT_VSHRINK];
	assign horiz_shrink_sel         = regs[IDX_OVL_SCALE][BIT_HSHRINK];
	assign vert_ratio               = regs[IDX_OVL_SCALE][27:16];
	assign horiz_ratio              = regs[IDX_OVL_SCALE][11:0];
	assign vert_ratio_init          = regs[IDX_OVL_INIT][27:16];
	assign horiz_ratio_init         = regs[IDX_OVL_INIT][11:0];
	assign pointer_sprite_show      = regs[IDX_CUR_ADDR][BIT_CUR_SHOW];
	assign pointer_sprite_ext       = regs[IDX_CUR_ADDR][BIT_EXT_SRC];
	assign pointer_sprite_addr      = regs[IDX_CUR_ADDR][25:4];
	assign pointer_sprite_y         = regs[IDX_CUR_POS][26:16];
	assign pointer_sprite_x         = regs[IDX_CUR_POS][10:0];
	assign pointer_sprite_top_clip  = regs[IDX_CUR_POS][BIT_CUR_TOP];
	assign pointer_sprite_left_clip = regs[IDX_CUR_POS][BIT_CUR_LEFT];
	assign cursor_shade_a           = regs[IDX_CUR_COL12][15:0];
	assign cursor_shade_b           = regs[IDX_CUR_COL12][31:16];
	assign cursor_shade_c           = regs[IDX_CUR_COL3][15:0];
	assign blend_pan_start          = bctl[7:4];
	assign key_match_on             = bctl[BIT_KEY_ON];
	assign blend_plane_on           = bctl[BIT_PLANE_ON];

endmodule : opc_regs

// ---- hdl/opc_pkg.sv ----
package opc_pkg;

	localparam int         REG_COUNT       = 21;
	localparam int         ADDR_W          = 20;
	localparam int         IDX_W           = 5;

	localparam logic [19:0] OFS_OVL_FB_ADDR  = 20'h80084;
	localparam logic [19:0] OFS_OVL_PITCH    = 20'h80088;
	localparam logic [19:0] OFS_OVL_FB_END   = 20'h8008C;
	localparam logic [19:0] OFS_OVL_TL       = 20'h80090;
	localparam logic [19:0] OFS_OVL_BR       = 20'h80094;
	localparam logic [19:0] OFS_OVL_SCALE    = 20'h80098;
	localparam logic [19:0] OFS_OVL_INIT     = 20'h8009C;
	localparam logic [19:0] OFS_OVL_KEY      = 20'h800A0;
	localparam logic [19:0] OFS_OVL_PAL_LO   = 20'h800A4;
	localparam logic [19:0] OFS_OVL_PAL_HI   = 20'h800C0;
	localparam logic [19:0] OFS_CUR_ADDR     = 20'h800F0;
	localparam logic [19:0] OFS_CUR_POS      = 20'h800F4;
	localparam logic [19:0] OFS_CUR_COL12    = 20'h800F8;
	localparam logic [19:0] OFS_CUR_COL3     = 20'h800FC;
	localparam logic [19:0] OFS_BLEND_CTRL   = 20'h80100;

	localparam logic [4:0] IDX_OVL_FB_ADDR  = 5'h00;
	localparam logic [4:0] IDX_OVL_PITCH    = 5'h01;
	localparam logic [4:0] IDX_OVL_FB_END   = 5'h02;
	localparam logic [4:0] IDX_OVL_TL       = 5'h03;
	localparam logic [4:0] IDX_OVL_BR       = 5'h04;
	localparam logic [4:0] IDX_OVL_SCALE    = 5'h05;
	localparam logic [4:0] IDX_OVL_INIT     = 5'h06;
	localparam logic [4:0] IDX_OVL_KEY      = 5'h07;
	localparam logic [4:0] IDX_OVL_PAL      = 5'h08;
	localparam logic [4:0] IDX_CUR_ADDR     = 5'h10;
	localparam logic [4:0] IDX_CUR_POS      = 5'h11;
	localparam logic [4:0] IDX_CUR_COL12    = 5'h12;
	localparam logic [4:0] IDX_CUR_COL3     = 5'h13;
	localparam logic [4:0] IDX_BLEND_CTRL   = 5'h14;
	localparam logic [4:0] IDX_NONE         = 5'h1F;

	localparam logic [31:0] MASK_FB_ADDR    = 32'h0BFF_FFF0;
	localparam logic [31:0] MASK_PITCH      = 32'h3FF0_3FF0;
	localparam logic [31:0] MASK_CORNER     = 32'h07FF_07FF;
	localparam logic [31:0] MASK_SCALE      = 32'h8FFF_8FFF;
	localparam logic [31:0] MASK_INIT       = 32'h0FFF_0FFF;
	localparam logic [31:0] MASK_FULL       = 32'hFFFF_FFFF;
	localparam logic [31:0] MASK_CUR_ADDR   = 32'h8BFF_FFF0;
	localparam logic [31:0] MASK_CUR_POS    = 32'h0FFF_0FFF;
	localparam logic [31:0] MASK_LOW_HALF   = 32'h0000_FFFF;
	localparam logic [31:0] MASK_BLEND_CTRL = 32'h1F03_00FF;
	localparam logic [31:0] MASK_NONE       = 32'h0000_0000;
	localparam logic [31:0] REG_RESET       = 32'h0000_0000;

	localparam int BIT_FLIP_PEND  = 31;
	localparam int BIT_EXT_SRC    = 27;
	localparam int BIT_CUR_SHOW   = 31;
	localparam int BIT_CUR_TOP    = 27;
	localparam int BIT_CUR_LEFT   = 11;
	localparam int BIT_VSHRINK    = 31;
	localparam int BIT_HSHRINK    = 15;
	localparam int BIT_ALPHA_SEL  = 28;
	localparam int BIT_KEY_ON     = 3;
	localparam int BIT_PLANE_ON   = 2;

	localparam logic [3:0] FIFO_LVL_0 = 4'h1;
	localparam logic [3:0] FIFO_LVL_1 = 4'h3;
	localparam logic [3:0] FIFO_LVL_2 = 4'h7;
	localparam logic [3:0] FIFO_LVL_3 = 4'hB;

	typedef enum logic [1:0] {FMT_INDEX8, FMT_RGB565, FMT_ALPHA_INDEX44, FMT_ARGB4444} opc_fmt_t;

endpackage : opc_pkg

// ---- testbench/opc_regs_sva.sv ----
`timescale 1ns/1ns
module opc_regs_chk
	import opc_pkg::*;
(
	input logic              clk,
	input logic              reset,
	input logic              reg_wr,
	input logic              reg_rd,
	input logic [ADDR_W-1:0] reg_addr,
	input logic [31:0]       reg_wdata,
	input logic [31:0]       reg_rdata,
	input logic              reg_rd_valid,
	input logic              vsync,
	input logic [1:0]        ovl_format_code,
	input logic [31:0]       ovl_fb_live,
	input logic              ovl_flip_pending,
	input logic              vert_shrink_sel,
	input logic              horiz_shrink_sel,
	input logic [11:0]       vert_ratio,
	input opc_fmt_t          ovl_format,
	input logic              pointer_sprite_show,
	input opc_fmt_t          blend_format,
	input logic              blend_format_bad
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence fb_write;
		reg_wr && reg_addr == OFS_OVL_FB_ADDR;
	endsequence
	sequence flip_takeup;
		ovl_flip_pending && vsync && !(reg_wr && reg_addr == OFS_OVL_FB_ADDR);
	endsequence
	chk_unmapped_read_zero: assert property (
		reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rd_valid && reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_flip_set: assert property (fb_write |=> ovl_flip_pending)
		else $error("flip pending not set");
	chk_flip_clear: assert property (flip_takeup |=> !ovl_flip_pending)
		else $error("flip pending not cleared");
	chk_flip_hold: assert property (ovl_flip_pending && !vsync |=> ovl_flip_pending)
		else $error("flip pending dropped early");
	chk_live_stable: assert property (
		!(ovl_flip_pending && vsync) |=> $stable(ovl_fb_live))
		else $error("live address moved without take-up");
	chk_flip_status: assert property (
		reg_rd && reg_addr == OFS_OVL_FB_ADDR |=> reg_rdata[31] == $past(ovl_flip_pending))
		else $error("status bit differs from pending");
	chk_sprite_show: assert property (
		reg_wr && reg_addr == OFS_CUR_ADDR |=> pointer_sprite_show == $past(reg_wdata[31]))
		else $error("cursor show bit wrong");
	chk_scale_fields: assert property (
		reg_wr && reg_addr == OFS_OVL_SCALE |=> vert_shrink_sel == $past(reg_wdata[31])
		&& horiz_shrink_sel == $past(reg_wdata[15]) && vert_ratio == $past(reg_wdata[27:16]))
		else $error("scale fields wrong");
	chk_ovl_format: assert property (
		1'b1 |=> ovl_format == opc_fmt_t'($past(ovl_format_code)))
		else $error("overlay format decode wrong");
	chk_bad_format: assert property (
		!$past(reset) |-> blend_format_bad == (blend_format == FMT_INDEX8))
		else $error("reserved format flag wrong");
endmodule : opc_regs_chk
bind opc_regs opc_regs_chk chk_u (.*);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top
	import opc_pkg::*;
;
	logic        clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, vsync = 0, ovl_key_enable = 0;
	logic [19:0] reg_addr = 20'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [15:0] ovl_pixel = 16'h0;
	logic [3:0]  ovl_pixel_index = 4'h0, blend_pixel_alpha = 4'h0, blend_fifo_empty = 4'h0;
	logic [1:0]  ovl_format_code = 2'h0;
	logic        reg_rd_valid, ovl_flip_pending, vert_shrink_sel, horiz_shrink_sel;
	logic        ovl_key_transparent, pointer_sprite_show, pointer_sprite_ext, key_match_on;
	logic        pointer_sprite_top_clip, pointer_sprite_left_clip, blend_fifo_req;
	logic        blend_plane_on, blend_format_bad, ovl_fb_end_ext;
	logic [31:0] reg_rdata, ovl_fb_live;
	logic [21:0] pointer_sprite_addr, ovl_fb_end;
	logic [11:0] vert_ratio, horiz_ratio, vert_ratio_init, horiz_ratio_init;
	logic [10:0] pointer_sprite_y, pointer_sprite_x, ovl_top, ovl_left, ovl_bottom, ovl_right;
	logic [9:0]  ovl_window_width, line_pitch;
	logic [15:0] ovl_palette_color, cursor_shade_a, cursor_shade_b, cursor_shade_c;
	logic [3:0]  blend_alpha, blend_pan_start;
	opc_fmt_t    ovl_format, blend_format;
	int          n_mismatch = 0, compares = 0;
	logic [19:0] ofs [17] = '{OFS_OVL_FB_ADDR, OFS_OVL_PITCH, OFS_OVL_FB_END, OFS_OVL_TL,
		OFS_OVL_BR, OFS_OVL_SCALE, OFS_OVL_INIT, OFS_OVL_KEY, OFS_OVL_PAL_LO, OFS_OVL_PAL_HI,
		OFS_CUR_ADDR, OFS_CUR_POS, OFS_CUR_COL12, OFS_CUR_COL3, OFS_BLEND_CTRL, 20'h800C4,
		20'h80086};
	logic [31:0] rbk [17] = '{32'h8BFFFFF0, 32'h3FF03FF0, 32'h0BFFFFF0, 32'h07FF07FF,
		32'h07FF07FF, 32'h8FFF8FFF, 32'h0FFF0FFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
		32'h8BFFFFF0, 32'h0FFF0FFF, 32'hFFFFFFFF, 32'h0000FFFF, 32'h1F0300FF, 32'h0, 32'h0};
	logic [3:0]  thr [4] = '{4'h1, 4'h3, 4'h7, 4'hB};

	opc_regs dut_u (.*);

	always #50 clk = ~clk;

	task automatic results();
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		tick();
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		tick();
		reg_wr = 0;
	endtask : wr

	task automatic rd(input logic [19:0] a, input logic [31:0] exp, input string nm);
		tick();
		reg_rd = 1;
		reg_addr = a;
		tick();
		reg_rd = 0;
		chk("rd_valid", 32'h1, 32'(reg_rd_valid));
		chk(nm, exp, reg_rdata);
	endtask : rd

	task automatic pulse();
		tick();
		vsync = 1;
		tick();
		vsync = 0;
	endtask : pulse

	initial
	begin
		#500000;
		n_mismatch++;
		results();
	end

	initial
	begin
		repeat (3) @(posedge clk);
		#1;
		reset = 0;
		for (int i = 0; i < 17; i++)
			rd(ofs[i], 32'h0, "reset value");
		for (int i = 0; i < 17; i++)
		begin
			wr(ofs[i], 32'hFFFFFFFF);
			rd(ofs[i], rbk[i], "readback");
		end
		// flip take-up, write racing vsync, idle vsync
		pulse();
		chk("pending", 32'h0, 32'(ovl_flip_pending));
		chk("live", 32'h0BFFFFF0, ovl_fb_live);
		wr(OFS_OVL_FB_ADDR, 32'h08000010);
		rd(OFS_OVL_FB_ADDR, 32'h88000010, "flip status");
		tick();
		reg_wr = 1;
		reg_wdata = 32'h00ABCDEF;
		vsync = 1;
		tick();
		reg_wr = 0;
		vsync = 0;
		chk("pending", 32'h1, 32'(ovl_flip_pending));
		chk("live", 32'h0BFFFFF0, ovl_fb_live);
		pulse();
		chk("live", 32'h00ABCDE0, ovl_fb_live);
		pulse();
		chk("live", 32'h00ABCDE0, ovl_fb_live);
		wr(OFS_OVL_PITCH, 32'h12345678);
		chk("width", 32'h123, 32'(ovl_window_width));
		chk("pitch", 32'h167, 32'(line_pitch));
		wr(OFS_OVL_SCALE, 32'h85550555);
		chk("ratios", 32'h05550555, {4'h0, vert_ratio, 4'h0, horiz_ratio});
		chk("dirs", 32'h2, 32'({vert_shrink_sel, horiz_shrink_sel}));
		wr(OFS_OVL_INIT, 32'hFABCF123);
		chk("init", 32'h0ABC0123, {4'h0, vert_ratio_init, 4'h0, horiz_ratio_init});
		wr(OFS_OVL_TL, 32'h01230456);
		wr(OFS_OVL_BR, 32'h07FF0001);
		chk("top left", 32'h01230456, {5'h0, ovl_top, 5'h0, ovl_left});
		chk("bottom right", 32'h07FF0001, {5'h0, ovl_bottom, 5'h0, ovl_right});
		wr(OFS_OVL_FB_END, 32'hF812345F);
		chk("fb end", 32'h00012345, 32'(ovl_fb_end));
		chk("end source", 32'h1, 32'(ovl_fb_end_ext));
		// chroma key with mask on the low byte
		wr(OFS_OVL_KEY, 32'h00FF1234);
		ovl_key_enable = 1;
		ovl_pixel = 16'h12AB;
		tick();
		chk("key hit", 32'h1, 32'(ovl_key_transparent));
		ovl_pixel = 16'h13AB;
		tick();
		chk("key miss", 32'h0, 32'(ovl_key_transparent));
		ovl_key_enable = 0;
		ovl_pixel = 16'h12AB;
		tick();
		chk("key off", 32'h0, 32'(ovl_key_transparent));
		for (int k = 0; k < 8; k++)
			wr(OFS_OVL_PAL_LO + 20'(4 * k), {16'hC001 + 16'(2 * k), 16'hC000 + 16'(2 * k)});
		for (int i = 0; i < 16; i++)
		begin
			ovl_pixel_index = 4'(i);
			tick();
			chk("palette", 32'hC000 + 32'(i), 32'(ovl_palette_color));
		end
		wr(OFS_CUR_ADDR, 32'h88001230);
		chk("cursor", 32'h0000048F, {30'(pointer_sprite_addr), pointer_sprite_show,
			pointer_sprite_ext});
		wr(OFS_CUR_ADDR, 32'h00001230);
		chk("cursor show", 32'h0, 32'(pointer_sprite_show));
		wr(OFS_CUR_POS, 32'h0ABC0DEF);
		chk("cursor pos", 32'h02BC05EF, {5'h0, pointer_sprite_y, 5'h0,
			pointer_sprite_x});
		chk("clips", 32'h3, 32'({pointer_sprite_top_clip, pointer_sprite_left_clip}));
		wr(OFS_CUR_COL12, 32'h11112222);
		wr(OFS_CUR_COL3, 32'hFFFF3333);
		chk("shades ab", 32'h11112222, {cursor_shade_b, cursor_shade_a});
		chk("shade c", 32'h3333, 32'(cursor_shade_c));
		blend_pixel_alpha = 4'h5;
		wr(OFS_BLEND_CTRL, 32'h1A0200B7);
		tick();
		chk("const alpha", 32'hAB01, {blend_alpha, blend_pan_start, 6'h0, key_match_on,
			blend_plane_on});
		wr(OFS_BLEND_CTRL, 32'h0A0200BB);
		tick();
		chk("pixel alpha", 32'h5B02, {blend_alpha, blend_pan_start, 6'h0, key_match_on,
			blend_plane_on});
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_BLEND_CTRL, (32'(i) << 16) | 32'(i));
			ovl_format_code = 2'(i);
			blend_fifo_empty = thr[i] - 4'h1;
			tick();
			chk("fifo below", 32'h0, 32'(blend_fifo_req));
			chk("blend format", 32'(i), 32'(blend_format));
			chk("format bad", 32'(i == 0), 32'(blend_format_bad));
			chk("ovl format", 32'(i), 32'(ovl_format));
			blend_fifo_empty = thr[i];
			tick();
			chk("fifo level", 32'h1, 32'(blend_fifo_req));
		end
		rd(20'h80086, 32'h0, "unmapped");
		results();
	end
endmodule : tb_top
